// ==== logic/ext_valid_detect.sv ====
// External oscillator valid detector: counts edges after enable
`timescale 1ns/1ps
module ext_valid_detect
  import osc_src_pkg::*;
#(
  parameter int EDGES = osc_src_pkg::VALID_EDGES
) (
  input  wire logic    clk,
  input  wire logic    resetn,
  ext_valid_if.det     vif
);
  import osc_src_pkg::*;

  // Elaboration check: the run must fit the edge counter
  if (EDGES < 1 || EDGES >= (1 << VALID_CNT_W)) begin : g_bad_edges
    $error("EDGES out of range for the edge counter");
  end

  localparam logic [VALID_CNT_W-1:0] EDGE_LIMIT = EDGES[VALID_CNT_W-1:0];

  logic [VALID_CNT_W-1:0] cnt_q;
  logic [VALID_CNT_W-1:0] cnt_d;
  logic                   valid_q;
  logic                   valid_d;

  always_comb begin
    cnt_d   = cnt_q;
    valid_d = valid_q;
    if (!vif.osc_enable) begin
      cnt_d   = '0;
      valid_d = 1'b0;
    end else if (vif.osc_edge && !valid_q) begin
      if (cnt_q == EDGE_LIMIT - 1'b1) begin
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign vif.valid = valid_q & ~vif.cmos_mode;
endmodule

// ==== logic/ext_valid_if.sv ====
// Interface: carrier between the source logic and the valid detector
`timescale 1ns/1ps
interface ext_valid_if;
  logic osc_enable;
  logic cmos_mode;
  logic osc_edge;
  logic valid;

  modport ctrl (
    output osc_enable,
    output cmos_mode,
    output osc_edge,
    input  valid
  );
  modport det (
    input  osc_enable,
    input  cmos_mode,
    input  osc_edge,
    output valid
  );
endinterface

// ==== logic/osc_src_pkg.sv ====
// Package: constants, encodings and types for the oscillator sources
package osc_src_pkg;
  // Source select field codes
  localparam logic [2:0] SEL_PRECISION = 3'h0;
  localparam logic [2:0] SEL_EXTERNAL  = 3'h1;
  localparam logic [2:0] SEL_RESERVED  = 3'h2;
  localparam logic [2:0] SEL_RTC       = 3'h3;
  localparam int         SEL_LP_BIT    = 2;

  // External oscillator mode codes
  localparam logic [2:0] EXT_OFF       = 3'h0;
  localparam logic [2:0] EXT_CMOS      = 3'h1;
  localparam logic [2:0] EXT_CRYSTAL   = 3'h2;
  localparam logic [2:0] EXT_CRYSTAL2  = 3'h3;
  localparam logic [2:0] EXT_RC        = 3'h4;
  localparam logic [2:0] EXT_CAP       = 3'h5;

  // Calibration register layout
  localparam int         TRIM_W        = 7;
  localparam int         CAL_DITHER_BIT = 7;
  localparam logic       DITHER_RESET  = 1'b0;

  // Nominal frequencies in kHz
  localparam int         PRECISION_KHZ = 24500;
  localparam int         LOWPOWER_KHZ  = 20000;

  // Dither: triangle period of 384 oscillator cycles, 6 steps of 0.26%
  localparam int         DITHER_DIV    = 384;
  localparam int         DITHER_STEPS  = 6;
  localparam int         DITHER_STEP_BP = 26;
  localparam int         DITHER_MAX_BP = 160;
  localparam int         DITHER_HOLD   = DITHER_DIV / (2 * DITHER_STEPS);
  localparam int         DITHER_CNT_W  = 6;

  // Valid detector: oscillator edges to see after enable
  localparam int         VALID_EDGES   = 1024;
  localparam int         VALID_CNT_W   = 11;

  typedef enum logic [3:0] {
    SRC_LOWPOWER  = 4'h1,
    SRC_PRECISION = 4'h2,
    SRC_EXTERNAL  = 4'h4,
    SRC_RTC       = 4'h8
  } sysclk_src_e;
endpackage

// ==== logic/system_oscillator_sources.sv ====
// Oscillator source logic: trim, dither, source select, external drive
//
// Functional notes
// - Trim field loads factory value at reset, giving nominal 24.5 MHz.
// - Dither is a stepped triangle at oscillator frequency over 384.
// - Dither only lowers frequency, down to -1.6%, in 0.26% steps.
// - After reset the low-power 20 MHz oscillator is the system clock.
// - Low-power oscillator is on only while it is the selected source.
// - External clock feeds both system clock mux and peripheral clock.
// - Crystal mode offers a divide-by-two stage giving 50% duty cycle.
// - A valid flag tells software when the external oscillator is stable.
// - Valid flag reads zero whenever the CMOS clock mode is chosen.
// - Select 000 precision, 001 external, 011 RTC, 1xx low-power.
// - Dither enable is bit 7 of the calibration register.
`timescale 1ns/1ps
module system_oscillator_sources
  import osc_src_pkg::*;
#(
  parameter logic [6:0] FACTORY_TRIM = 7'h40,
  parameter int         VALID_RUN    = osc_src_pkg::VALID_EDGES
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       cal_wr,
  input  wire logic [7:0]                 cal_wdata,
  output logic [7:0]                      cal_rdata,
  input  wire logic [2:0]                 sysclk_source_select,
  output osc_src_pkg::sysclk_src_e        sysclk_source,
  output logic                            lp_osc_enable,
  output logic                            precision_osc_active,
  output logic [osc_src_pkg::TRIM_W-1:0]  precision_osc_trim,
  output logic [2:0]                      dither_lower_steps,
  input  wire logic [2:0]                 ext_osc_mode,
  input  wire logic [2:0]                 ext_drive_level,
  output logic [2:0]                      ext_drive_level_out,
  input  wire logic                       osc_pin_b_in,
  output logic                            osc_pin_a_digital,
  output logic                            osc_pin_b_digital,
  output logic                            ext_osc_clk,
  output logic                            ext_periph_clk,
  output logic                            ext_osc_valid_flag
);
  import osc_src_pkg::*;

  // Elaboration check: the run must fit the detector's counter
  if (VALID_RUN < 1 || VALID_RUN >= (1 << VALID_CNT_W)) begin : g_bad_run
    $error("VALID_RUN out of range");
  end

  localparam logic [DITHER_CNT_W-1:0] HOLD_LAST =
    DITHER_CNT_W'(DITHER_HOLD - 1);
  localparam logic [2:0] STEP_TOP = 3'(DITHER_STEPS);

  // Calibration register state
  logic [TRIM_W-1:0]       trim_q;
  logic [TRIM_W-1:0]       trim_d;
  logic                    dith_en_q;
  logic                    dith_en_d;

  // Dither triangle state
  logic [DITHER_CNT_W-1:0] hold_q;
  logic [DITHER_CNT_W-1:0] hold_d;
  logic [2:0]              step_q;
  logic [2:0]              step_d;
  logic                    down_q;
  logic                    down_d;

  // Source select state
  sysclk_src_e             src_q;
  sysclk_src_e             src_d;

  // External oscillator path
  logic                    pin_q;
  logic                    pin_d;
  logic                    div_q;
  logic                    div_d;
  logic                    clk_q;
  logic                    clk_d;
  logic                    rise;
  logic                    ext_on;

  ext_valid_if vif ();

  always_comb begin
    trim_d    = trim_q;
    dith_en_d = dith_en_q;
    if (cal_wr) begin
      trim_d    = cal_wdata[TRIM_W-1:0];
      dith_en_d = cal_wdata[CAL_DITHER_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      trim_q    <= FACTORY_TRIM;
      dith_en_q <= DITHER_RESET;
    end else begin
      trim_q    <= trim_d;
      dith_en_q <= dith_en_d;
    end
  end

  // The oscillator's own cycles are stood in for by clk edges here
  always_comb begin
    hold_d = hold_q;
    step_d = step_q;
    down_d = down_q;
    if (!dith_en_q) begin
      hold_d = '0;
      step_d = '0;
      down_d = 1'b0;
    end else if (hold_q != HOLD_LAST) begin
      hold_d = hold_q + 1'b1;
    end else begin
      // 12 steps of 32 cycles per period of 384
      hold_d = '0;
      if (!down_q) begin
        // lower by one step, never past -1.6%
        step_d = step_q + 1'b1;
        down_d = (step_q == STEP_TOP - 1'b1);
      end else begin
        step_d = step_q - 1'b1;
        down_d = (step_q != 3'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_q <= '0;
      step_q <= '0;
      down_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      step_q <= step_d;
      down_q <= down_d;
    end
  end

  always_comb begin
    src_d = src_q;
    if (sysclk_source_select[SEL_LP_BIT]) begin
      src_d = SRC_LOWPOWER;
    end else begin
      case (sysclk_source_select)
        SEL_PRECISION: src_d = SRC_PRECISION;
        SEL_EXTERNAL:  src_d = SRC_EXTERNAL;
        SEL_RTC:       src_d = SRC_RTC;
        // Reserved code keeps the running source rather than glitch
        default:       src_d = src_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_q <= SRC_LOWPOWER;
    end else begin
      src_q <= src_d;
    end
  end

  assign ext_on = (ext_osc_mode == EXT_CMOS)
                | (ext_osc_mode == EXT_CRYSTAL)
                | (ext_osc_mode == EXT_CRYSTAL2)
                | (ext_osc_mode == EXT_RC)
                | (ext_osc_mode == EXT_CAP);
  assign rise   = pin_d & ~pin_q;

  always_comb begin
    pin_d = ext_on ? osc_pin_b_in : 1'b0;
    div_d = div_q;
    clk_d = pin_q;
    if (ext_osc_mode == EXT_CRYSTAL2) begin
      // divide by two for even duty
      if (rise) begin
        div_d = ~div_q;
      end
      clk_d = div_q;
    end else begin
      div_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_q <= 1'b0;
      div_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      div_q <= div_d;
      clk_q <= clk_d;
    end
  end

  assign vif.osc_enable = ext_on;
  assign vif.cmos_mode  = (ext_osc_mode == EXT_CMOS);
  assign vif.osc_edge   = rise;

  ext_valid_detect #(
    .EDGES (VALID_RUN)
  ) u_valid (
    .clk    (clk),
    .resetn (resetn),
    .vif    (vif)
  );

  assign ext_osc_valid_flag   = vif.valid;
  assign cal_rdata            = {dith_en_q, trim_q};
  assign sysclk_source        = src_q;
  assign lp_osc_enable        = (src_q == SRC_LOWPOWER);
  assign precision_osc_active = (src_q == SRC_PRECISION);
  assign precision_osc_trim   = trim_q;
  assign dither_lower_steps   = step_q;
  assign ext_drive_level_out  = ext_drive_level;
  // CMOS mode uses pin b digital
  assign osc_pin_b_digital    = (ext_osc_mode == EXT_CMOS);
  assign osc_pin_a_digital    = ~((ext_osc_mode == EXT_CRYSTAL)
                                | (ext_osc_mode == EXT_CRYSTAL2));
  assign ext_osc_clk          = clk_q;
  assign ext_periph_clk       = clk_q;
endmodule

// ==== testbench/osc_partner.sv ====
// External oscillator model feeding the second oscillator pin
`timescale 1ns/1ps
module osc_partner
  import osc_src_pkg::*;
#(
  parameter int HALF = 3
) (
  input  wire logic       clk,
  input  wire logic [2:0] mode,
  output logic            pin
);
  int cnt;
  initial begin
    pin = 1'b0;
    cnt = 0;
  end
  // clock runs in any enabled mode, stops when off
  always @(posedge clk) begin
    if (mode inside {[EXT_CMOS:EXT_CAP]}) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) pin <= ~pin;
    end else begin
      // A stopped oscillator rests low, so no false edge on re-enable
      cnt <= 0;
      pin <= 1'b0;
    end
  end
endmodule

// ==== testbench/system_oscillator_sources_asserts.sv ====
// Checker for source select, calibration and valid flag behaviour
`timescale 1ns/1ps
module system_oscillator_sources_asserts
  import osc_src_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       cal_wr,
  input wire logic [7:0] cal_wdata,
  input wire logic [7:0] cal_rdata,
  input wire logic [2:0] sysclk_source_select,
  input sysclk_src_e     sysclk_source,
  input wire logic       lp_osc_enable,
  input wire logic       precision_osc_active,
  input wire logic [2:0] ext_osc_mode,
  input wire logic       ext_osc_clk,
  input wire logic       ext_periph_clk,
  input wire logic       ext_osc_valid_flag,
  input wire logic [2:0] dither_lower_steps
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_on_pre;
    sysclk_source == SRC_PRECISION && precision_osc_active && !lp_osc_enable;
  endsequence
  property p_lp;
    lp_osc_enable == (sysclk_source == SRC_LOWPOWER);
  endproperty
  a_lp: assert property (p_lp) else $error("lp enable mismatch");
  property p_pre;
    sysclk_source_select == SEL_PRECISION |=> s_on_pre;
  endproperty
  a_pre: assert property (p_pre) else $error("precision select");
  property p_ext;
    sysclk_source_select == SEL_EXTERNAL |=> sysclk_source == SRC_EXTERNAL;
  endproperty
  a_ext: assert property (p_ext) else $error("external select");
  property p_low;
    sysclk_source_select[2] |=> sysclk_source == SRC_LOWPOWER;
  endproperty
  a_low: assert property (p_low) else $error("lowpower select");
  property p_rsv;
    sysclk_source_select == SEL_RESERVED |=> $stable(sysclk_source);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved select");
  property p_cmos;
    ext_osc_mode == EXT_CMOS |-> !ext_osc_valid_flag;
  endproperty
  a_cmos: assert property (p_cmos) else $error("valid in cmos");
  property p_off;
    ext_osc_mode == EXT_OFF |=> !ext_osc_valid_flag;
  endproperty
  a_off: assert property (p_off) else $error("valid while off");
  property p_cal;
    cal_wr |=> cal_rdata == $past(cal_wdata);
  endproperty
  a_cal: assert property (p_cal) else $error("cal readback");
  property p_per;
    ext_periph_clk == ext_osc_clk;
  endproperty
  a_per: assert property (p_per) else $error("periph clock");
  property p_dmax;
    dither_lower_steps <= DITHER_STEPS;
  endproperty
  a_dmax: assert property (p_dmax) else $error("dither too deep");
endmodule
bind system_oscillator_sources system_oscillator_sources_asserts u_chk (
  .clk(clk), .resetn(resetn), .cal_wr(cal_wr), .cal_wdata(cal_wdata),
  .cal_rdata(cal_rdata), .sysclk_source_select(sysclk_source_select),
  .sysclk_source(sysclk_source), .lp_osc_enable(lp_osc_enable),
  .precision_osc_active(precision_osc_active), .ext_osc_mode(ext_osc_mode),
  .ext_osc_clk(ext_osc_clk), .ext_periph_clk(ext_periph_clk),
  .ext_osc_valid_flag(ext_osc_valid_flag),
  .dither_lower_steps(dither_lower_steps));

// ==== testbench/test_system_oscillator_sources.sv ====
// Self-checking bench for the oscillator source logic
`timescale 1ns/1ps
module test_system_oscillator_sources;
  import osc_src_pkg::*;
  logic clk, resetn, cal_wr, pin, pa, pb, eclk, pclk, vld, act, lpe;
  logic [7:0] wd, rd;
  logic [2:0] sel, mode, drv, drvo, stp;
  logic [6:0] trim;
  sysclk_src_e src;
  int error_cnt, n_checks, cyc, c;
  logic [2:0] rs [8] = '{0, 1, 2, 3, 4, 7, 5, 6};
  sysclk_src_e re [8] = '{SRC_PRECISION, SRC_EXTERNAL, SRC_EXTERNAL,
    SRC_RTC, SRC_LOWPOWER, SRC_LOWPOWER, SRC_LOWPOWER, SRC_LOWPOWER};
  int off [6] = '{16, 48, 208, 240, 400, 432};
  logic [2:0] de [6] = '{0, 1, 6, 5, 0, 1};
  system_oscillator_sources #(.FACTORY_TRIM(7'h40), .VALID_RUN(4)) uut (
    .clk(clk), .resetn(resetn), .cal_wr(cal_wr), .cal_wdata(wd),
    .cal_rdata(rd), .sysclk_source_select(sel), .sysclk_source(src),
    .lp_osc_enable(lpe), .precision_osc_active(act),
    .precision_osc_trim(trim), .dither_lower_steps(stp),
    .ext_osc_mode(mode), .ext_drive_level(drv), .ext_drive_level_out(drvo),
    .osc_pin_b_in(pin), .osc_pin_a_digital(pa), .osc_pin_b_digital(pb),
    .ext_osc_clk(eclk), .ext_periph_clk(pclk), .ext_osc_valid_flag(vld));
  osc_partner #(.HALF(3)) u_osc (.clk(clk), .mode(mode), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task setm(input logic [2:0] m);
    @(posedge clk) mode <= m;
  endtask
  // Counting keeps a hang bounded
  task cnt_rise(input int n);
    logic p;
    #1;
    c = 0;
    p = eclk;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (eclk === 1'b1 && p === 1'b0) c++;
      p = eclk;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {resetn, cal_wr, wd, sel, mode, drv} = '0;
    sel = 3'h4;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    step(1);
    chk(rd, 8'h40);
    chk(src, SRC_LOWPOWER);
    chk(vld, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) sel <= rs[i];
      step(1);
      chk(src, re[i]);
      chk(lpe, re[i] == SRC_LOWPOWER);
    end
    $display("test select done");
    @(posedge clk) {cal_wr, wd} <= {1'b1, 8'h85};
    @(posedge clk) cal_wr <= 1'b0;
    #1 chk(rd, 8'h85);
    chk(trim, 7'h05);
    c = 0;
    for (int k = 1; k <= 432; k++) begin
      step(1);
      if (stp > 3'h6) c++;
      for (int j = 0; j < 6; j++) if (k == off[j]) chk(stp, de[j]);
    end
    chk(c, 0);
    @(posedge clk) {cal_wr, wd} <= {1'b1, 8'h05};
    @(posedge clk) cal_wr <= 1'b0;
    step(2);
    chk(stp, 3'h0);
    $display("test dither done");
    // Drive level by crystal band, then enable; crystal mode puts the pins analog
    @(posedge clk) drv <= 3'h7;
    setm(EXT_CRYSTAL);
    step(2);
    chk(vld, 1'b0);
    chk(drvo, 3'h7);
    chk(pa, 1'b0);
    c = 0;
    while (vld !== 1'b1 && c < 200) begin
      step(1);
      c++;
    end
    chk(vld, 1'b1);
    @(posedge clk) sel <= SEL_EXTERNAL;
    cnt_rise(60);
    chk(c >= 9, 1'b1);
    chk(pclk, eclk);
    setm(EXT_CRYSTAL2);
    cnt_rise(60);
    chk(c inside {[4:6]}, 1'b1);
    setm(EXT_CMOS);
    step(1);
    chk(vld, 1'b0);
    chk(pb, 1'b1);
    setm(EXT_OFF);
    step(1);
    chk(vld, 1'b0);
    // RC band code, second pin analog, then enable
    @(posedge clk) drv <= 3'h2;
    setm(EXT_RC);
    step(1);
    chk({pa, pb}, 2'b10);
    step(60);
    chk(vld, 1'b1);
    // Capacitor mode uses the RC bring-up order
    setm(EXT_OFF);
    step(1);
    chk(vld, 1'b0);
    setm(EXT_CAP);
    step(1);
    chk({pa, pb}, 2'b10);
    step(60);
    chk(vld, 1'b1);
    $display("test external done");
    // Mid-run reset must fall back to the low-power source
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) resetn <= 1'b1;
    #1 chk(src, SRC_LOWPOWER);
    chk(lpe, 1'b1);
    chk(rd, 8'h40);
    chk(vld, 1'b0);
    $display("test reset again done");
    finish_test();
  end
endmodule
